// ---- verilog/qsbr_regs.sv ----
// Statistics registers, bin width table, serial statistics sender and clock output
`include "qsbr_cfg.svh"
module qsbr_regs (
  input wire logic clk, // Video clock, 200 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire qsbr_pkg::qsbr_access_t host_access, // Host indirect access
  output logic [31:0] host_rdata, // Host read data
  output logic host_rvalid, // Read data valid pulse
  input wire qsbr_pkg::qsbr_access_t dsp_access, // DSP serial table write
  input wire logic stats_load, // Pulse: new field statistics
  input wire qsbr_pkg::qsbr_stats_t stats_in, // Gathered statistics
  input wire logic stats_ack, // Pulse: clears ready flag
  output logic stats_ready_flag, // Ready status bit
  output logic stats_ready_pin, // Ready output pin
  input wire logic serial_ready, // Serial port takes a word
  output qsbr_pkg::qsbr_serial_word_t serial_out, // Statistics word to DSP
  input wire logic [6:0] quant_pair, // Pair select from quantizer
  output qsbr_pkg::qsbr_quant_pair_t quant_out, // Bin width pair
  input wire logic clock_half_mode, // Mode: 1 divides clock by two
  output logic pixel_clock_out // Clock output pin
);
  import qsbr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Derived sizes
  localparam int unsigned PAIR_COUNT = `QSBR_TABLE_DEPTH / 2; // Quantizer pairs
  localparam int unsigned LAST_SLOT = `QSBR_STAT_COUNT - 1; // Final serial slot

  ////////////////////////////////////////////////////////////////////////////
  // Storage, no reset on statistics or table
  qsbr_stats_t stats;
  logic [15:0] table_mem [0:`QSBR_TABLE_DEPTH-1];

  // Table write select
  logic tab_we;
  logic [6:0] tab_slot;
  logic [15:0] tab_wdata;

  // Ready flag state
  logic ready;
  logic next_ready;

  // Clock divider state
  logic div_phase;
  logic next_div_phase;

  // Serial sender state
  qsbr_tx_state_t tx_state;
  qsbr_tx_state_t next_tx_state;
  logic [2:0] tx_slot;
  logic [2:0] next_tx_slot;
  logic [15:0] tx_data;
  logic [15:0] next_tx_data;

  // Host read state
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  // Quantizer lookup state
  logic pair_ok;
  qsbr_quant_pair_t qpair;
  qsbr_quant_pair_t next_qpair;

  // Table hit and offset for an index
  function automatic logic in_table(input logic [8:0] idx);
    in_table = (idx >= `QSBR_IDX_TABLE_FIRST) && (idx <= `QSBR_IDX_TABLE_LAST);
  endfunction

  function automatic logic [6:0] table_slot(input logic [8:0] idx);
    logic [8:0] off;
    off = idx - `QSBR_IDX_TABLE_FIRST;
    table_slot = off[6:0];
  endfunction

  // Table entry of one half of a quantizer pair
  function automatic logic [6:0] pair_entry(input logic [6:0] pair, input logic odd);
    pair_entry = {pair[5:0], odd};
  endfunction

  // Statistic by serial slot
  function automatic logic [15:0] stat_pick(input qsbr_stats_t s, input logic [2:0] k);
    logic [15:0] v;
    v = 16'h0000;
    unique case (k)
      3'h0: begin
        v = s.red_chroma_sum;
      end
      3'h1: begin
        v = s.luma_minimum;
      end
      3'h2: begin
        v = s.luma_maximum;
      end
      3'h3: begin
        v = s.blue_chroma_minimum;
      end
      3'h4: begin
        v = s.blue_chroma_maximum;
      end
      3'h5: begin
        v = s.red_chroma_minimum;
      end
      3'h6: begin
        v = s.red_chroma_maximum;
      end
      default: v = 16'h0000;
    endcase
    stat_pick = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Statistics capture; bus writes never reach these
  always_ff @(posedge clk) begin
    if (stats_load) begin
      stats <= stats_in;
    end
  end

  // Table write select; host wins a same-cycle clash
  always_comb begin
    tab_we = 1'b0;
    tab_slot = 7'h00;
    tab_wdata = 16'h0000;
    if (host_access.wr && in_table(host_access.index)) begin
      tab_we = 1'b1;
      tab_slot = table_slot(host_access.index);
      tab_wdata = host_access.wdata;
    end else if (dsp_access.wr && in_table(dsp_access.index)) begin
      tab_we = 1'b1;
      tab_slot = table_slot(dsp_access.index);
      tab_wdata = dsp_access.wdata;
    end
  end

  // Table storage, never reset
  always_ff @(posedge clk) begin
    if (tab_we) begin
      table_mem[tab_slot] <= tab_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host read decode, upper half always zero
  always_comb begin
    next_rvalid = host_access.rd;
    next_rdata = rdata;
    if (host_access.rd) begin
      next_rdata = 32'h00000000;
      if (in_table(host_access.index)) begin
        next_rdata[15:0] = table_mem[table_slot(host_access.index)];
      end else begin
        unique case (host_access.index)
          `QSBR_IDX_RED_SUM: begin
            next_rdata[15:0] = stats.red_chroma_sum;
          end
          `QSBR_IDX_LUMA_MIN: begin
            next_rdata[15:0] = stats.luma_minimum;
          end
          `QSBR_IDX_LUMA_MAX: begin
            next_rdata[15:0] = stats.luma_maximum;
          end
          `QSBR_IDX_BLUE_MIN: begin
            next_rdata[15:0] = stats.blue_chroma_minimum;
          end
          `QSBR_IDX_BLUE_MAX: begin
            next_rdata[15:0] = stats.blue_chroma_maximum;
          end
          `QSBR_IDX_RED_MIN: begin
            next_rdata[15:0] = stats.red_chroma_minimum;
          end
          `QSBR_IDX_RED_MAX: begin
            next_rdata[15:0] = stats.red_chroma_maximum;
          end
          default: next_rdata[15:0] = 16'h0000;
        endcase
      end
    end
  end

  // Quantizer lookup: even entry reciprocal 6.10, odd entry bin width 8.8
  always_comb begin
    pair_ok = ({1'b0, quant_pair} < 8'(PAIR_COUNT));
    next_qpair = qpair;
    if (pair_ok) begin
      next_qpair.reciprocal_bin_width = table_mem[pair_entry(quant_pair, 1'b0)];
      next_qpair.bin_width = table_mem[pair_entry(quant_pair, 1'b1)];
    end
  end

  // Host read registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Quantizer pair register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      qpair <= '0;
    end else begin
      qpair <= next_qpair;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready flag: new field sets, ack clears, set wins
  always_comb begin
    next_ready = ready;
    if (stats_ack) begin
      next_ready = 1'b0;
    end
    if (stats_load) begin
      next_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ready <= 1'b0;
    end else begin
      ready <= next_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial sender: seven words per field after capture
  // Data word is registered; a load takes the word straight from stats_in
  always_comb begin
    next_tx_state = tx_state;
    next_tx_slot = tx_slot;
    next_tx_data = tx_data;
    unique case (tx_state)
      QSBR_TX_IDLE: begin
        if (stats_load) begin
          next_tx_state = QSBR_TX_SEND;
          next_tx_slot = 3'h0;
          next_tx_data = stat_pick(stats_in, 3'h0);
        end
      end
      QSBR_TX_SEND: begin
        if (stats_load) begin
          next_tx_slot = 3'h0;
          next_tx_data = stat_pick(stats_in, 3'h0);
        end else if (serial_ready) begin
          if (tx_slot == 3'(LAST_SLOT)) begin
            next_tx_state = QSBR_TX_IDLE;
            next_tx_slot = 3'h0;
            next_tx_data = 16'h0000;
          end else begin
            next_tx_slot = tx_slot + 3'h1;
            next_tx_data = stat_pick(stats, tx_slot + 3'h1);
          end
        end
      end
      default: begin
        next_tx_state = QSBR_TX_IDLE;
        next_tx_slot = 3'h0;
        next_tx_data = 16'h0000;
      end
    endcase
  end

  // Serial sender registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_state <= QSBR_TX_IDLE;
      tx_slot <= 3'h0;
      tx_data <= 16'h0000;
    end else begin
      tx_state <= next_tx_state;
      tx_slot <= next_tx_slot;
      tx_data <= next_tx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock output divider
  always_comb begin
    next_div_phase = ~div_phase;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_phase <= 1'b0;
    end else begin
      div_phase <= next_div_phase;
    end
  end

  // Full rate passes the clock gated by reset_n, half rate the divider
  assign pixel_clock_out = clock_half_mode ? div_phase : (clk & reset_n);

  // Host bus outputs
  assign host_rdata = rdata;
  assign host_rvalid = rvalid;

  // Ready flag and pin carry the same level
  assign stats_ready_flag = ready;
  assign stats_ready_pin = ready;

  // Quantizer pair output
  assign quant_out = qpair;

  // Serial word toward the DSP
  assign serial_out.valid = (tx_state == QSBR_TX_SEND);
  assign serial_out.slot = tx_slot;
  assign serial_out.data = tx_data;
endmodule

// ---- common/qsbr_cfg.svh ----
// Register indices, field layouts and constants for the quantizer statistics and bin width bank
// Operation
// - Index 0x0ac reads the block 41 red chroma sum, 16 bits.
// - Index 0x0ad reads the field's smallest unprocessed luma sample.
// - Index 0x0ae reads the field's largest unprocessed luma sample.
// - Indices 0x0af and 0x0b0 read blue chroma minimum and maximum.
// - Indices 0x0b1 and 0x0b2 read red chroma minimum and maximum.
// - Statistics are read only; bits above the 16-bit value read zero.
// - Statistics need no reset; undefined until the first field is gathered.
// - Statistics reach both host reads and the serial port transmitter.
// - A read/write table of 84 16-bit entries sits at 0x100 to 0x153.
// - Even table indices hold reciprocal bin widths, odd ones bin widths.
// - Bin widths are unsigned 8.8 fixed point.
// - Reciprocal bin widths are unsigned 6.10 fixed point.
// - The table is not reset; entries are undefined until written.
// - The clock output carries the video clock or half of it, by mode; it stays low while reset_n is low.
// - New field statistics set a ready status bit and a ready pin.
`ifndef QSBR_CFG_SVH
`define QSBR_CFG_SVH
`define QSBR_IDX_RED_SUM 9'h0ac
`define QSBR_IDX_LUMA_MIN 9'h0ad
`define QSBR_IDX_LUMA_MAX 9'h0ae
`define QSBR_IDX_BLUE_MIN 9'h0af
`define QSBR_IDX_BLUE_MAX 9'h0b0
`define QSBR_IDX_RED_MIN 9'h0b1
`define QSBR_IDX_RED_MAX 9'h0b2
`define QSBR_IDX_TABLE_FIRST 9'h100
`define QSBR_IDX_TABLE_LAST 9'h153
`define QSBR_TABLE_DEPTH 84
`define QSBR_STAT_COUNT 7
`define QSBR_BW_INT_BITS 8
`define QSBR_RBW_INT_BITS 6
`endif

// ---- common/qsbr_pkg.sv ----
// Types shared by the quantizer statistics and bin width bank
package qsbr_pkg;
  // One indirect register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] index;
    logic [15:0] wdata;
  } qsbr_access_t;
  // One field's worth of gathered statistics
  typedef struct packed {
    logic [15:0] red_chroma_sum;
    logic [15:0] luma_minimum;
    logic [15:0] luma_maximum;
    logic [15:0] blue_chroma_minimum;
    logic [15:0] blue_chroma_maximum;
    logic [15:0] red_chroma_minimum;
    logic [15:0] red_chroma_maximum;
  } qsbr_stats_t;
  // Serial port word stream toward the DSP
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [15:0] data;
  } qsbr_serial_word_t;
  // Table lookup by the quantizer
  typedef struct packed {
    logic [15:0] bin_width;
    logic [15:0] reciprocal_bin_width;
  } qsbr_quant_pair_t;
  typedef enum logic [1:0] {
    QSBR_TX_IDLE = 2'b00,
    QSBR_TX_SEND = 2'b01
  } qsbr_tx_state_t;
endpackage

// ---- verification/qsbr_regs_chk.sv ----
// Port checker for the statistics and bin width bank
module qsbr_regs_chk (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire qsbr_pkg::qsbr_access_t host_access, // Host access
  input wire logic [31:0] host_rdata, // Read data
  input wire logic host_rvalid, // Read valid
  input wire logic stats_load, // Load pulse
  input wire qsbr_pkg::qsbr_stats_t stats_in, // Statistics
  input wire logic stats_ack, // Ack pulse
  input wire logic stats_ready_flag, // Ready bit
  input wire logic stats_ready_pin, // Ready pin
  input wire logic serial_ready, // Sink ready
  input wire qsbr_pkg::qsbr_serial_word_t serial_out, // Serial word
  input wire logic clock_half_mode, // Divide mode
  input wire logic pixel_clock_out // Clock out
);
  import qsbr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Host read answer and upper bits
  a_read_answer: assert property (host_access.rd |=> host_rvalid)
    else $error("read not answered");
  a_no_answer: assert property (!host_access.rd |=> !host_rvalid)
    else $error("spurious read valid");
  a_rdata_upper: assert property (host_rvalid |-> host_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // Ready flag and pin
  a_ready_set: assert property (stats_load |=> stats_ready_flag && stats_ready_pin)
    else $error("ready not set");
  a_ready_clear: assert property (stats_ack && !stats_load |=> !stats_ready_flag && !stats_ready_pin)
    else $error("ready not cleared");
  // Serial word sequence
  a_serial_first: assert property (stats_load |=> serial_out.valid && serial_out.slot == 3'h0
    && serial_out.data == $past(stats_in.red_chroma_sum)) else $error("bad first serial word");
  a_slot_step: assert property (serial_out.valid && serial_ready && serial_out.slot != 3'h6 && !stats_load
    |=> serial_out.valid && serial_out.slot == $past(serial_out.slot) + 3'h1) else $error("slot not stepped");
  a_serial_end: assert property (serial_out.valid && serial_ready && serial_out.slot == 3'h6 && !stats_load
    |=> !serial_out.valid) else $error("serial did not end");
  a_stall_hold: assert property (serial_out.valid && !serial_ready && !stats_load |=> $stable(serial_out))
    else $error("word changed in stall");
  // Divided clock output
  a_half_toggle: assert property (clock_half_mode && $past(clock_half_mode) && $past(reset_n)
    |-> pixel_clock_out != $past(pixel_clock_out)) else $error("half clock not toggling");
endmodule
bind qsbr_regs qsbr_regs_chk qsbr_regs_chk_i (.clk, .reset_n, .host_access, .host_rdata, .host_rvalid,
  .stats_load, .stats_in, .stats_ack, .stats_ready_flag, .stats_ready_pin, .serial_ready, .serial_out,
  .clock_half_mode, .pixel_clock_out);

// ---- verification/qsbr_dsp_model.sv ----
// Serial statistics sink in place of the DSP
module qsbr_dsp_model (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire qsbr_pkg::qsbr_serial_word_t serial_out, // Word in
  input wire logic slow, // Stall every other cycle
  output logic serial_ready, // Takes word
  output logic [15:0] words [7], // Words by slot
  output logic [3:0] n_words // Words taken
);
  import qsbr_pkg::*;
  // Ready pattern and capture
  always @(posedge clk) begin
    serial_ready <= reset_n && (!slow || !serial_ready);
    if (!reset_n)
      n_words <= 4'h0;
    else if (serial_out.valid && serial_ready) begin
      words[serial_out.slot] <= serial_out.data;
      n_words <= n_words + 4'h1;
    end
  end
endmodule

// ---- verification/tb_qsbr_regs.sv ----
// Self-checking bench for the statistics and bin width bank
module tb_qsbr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import qsbr_pkg::*;
  logic clk, reset_n, host_rvalid, stats_load, stats_ack, stats_ready_flag, stats_ready_pin;
  logic serial_ready, clock_half_mode, pixel_clock_out, slow;
  logic [31:0] host_rdata;
  logic [6:0] quant_pair;
  logic [3:0] n_words;
  logic [15:0] words [7];
  logic [15:0] exp_s [7] = '{16'h8001, 16'h0010, 16'h00f0, 16'h0020, 16'h00e0, 16'h0030, 16'h00d0};
  qsbr_access_t host_access, dsp_access;
  qsbr_stats_t stats_in;
  qsbr_serial_word_t serial_out;
  qsbr_quant_pair_t quant_out;
  int fails = 0;
  int n_tests = 0;
  qsbr_regs qsbr_regs_i (.clk, .reset_n, .host_access, .host_rdata, .host_rvalid, .dsp_access, .stats_load,
    .stats_in, .stats_ack, .stats_ready_flag, .stats_ready_pin, .serial_ready, .serial_out, .quant_pair,
    .quant_out, .clock_half_mode, .pixel_clock_out);
  qsbr_dsp_model qsbr_dsp_model_i (.clk, .reset_n, .serial_out, .slow, .serial_ready, .words, .n_words);
  ////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    fails++;
    close_out();
  end
  // Compare and host access helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic rd, input logic wr, input logic [8:0] idx, input logic [15:0] d);
    @(posedge clk);
    host_access <= '{rd, wr, idx, d};
    @(posedge clk);
    host_access <= '0;
  endtask
  task automatic rdchk(input logic [8:0] idx, input logic [15:0] e);
    acc(1'b1, 1'b0, idx, 16'h0000);
    #1;
    chk("host_rvalid", {31'h0, host_rvalid}, 32'h1);
    chk("host_rdata", host_rdata, {16'h0000, e});
  endtask
  // Statistics load, reads, refused writes, serial words, ack
  task automatic t_stats();
    @(posedge clk);
    stats_in <= {>>{exp_s}};
    stats_load <= 1'b1;
    stats_ack <= 1'b1;
    slow <= 1'b1;
    @(posedge clk);
    stats_load <= 1'b0;
    stats_ack <= 1'b0;
    #1 chk("ready", {stats_ready_flag, stats_ready_pin}, 32'h3);
    for (int k = 0; k < 7; k++) begin
      acc(1'b0, 1'b1, 9'h0ac + 9'(k), 16'hffff);
      rdchk(9'h0ac + 9'(k), exp_s[k]);
    end
    chk("n_words", n_words, 32'h7);
    for (int k = 0; k < 7; k++)
      chk("serial word", words[k], exp_s[k]);
    @(posedge clk);
    stats_ack <= 1'b1;
    @(posedge clk);
    stats_ack <= 1'b0;
    #1 chk("ready", {stats_ready_flag, stats_ready_pin}, 32'h0);
  endtask
  // Table fill, bounds, pairing, DSP writes
  task automatic t_table();
    @(posedge clk);
    clock_half_mode <= 1'b1;
    for (int k = 0; k < 84; k++)
      acc(1'b0, 1'b1, 9'h100 + 9'(k), 16'h3000 + 16'(k));
    rdchk(9'h100, 16'h3000);
    rdchk(9'h153, 16'h3053);
    rdchk(9'h154, 16'h0000);
    for (int k = 0; k < 42; k += 41) begin
      @(posedge clk);
      quant_pair <= 7'(k);
      @(posedge clk);
      #1 chk("quant_out", quant_out, {16'h3001 + 16'(2 * k), 16'h3000 + 16'(2 * k)});
    end
    @(posedge clk);
    dsp_access <= '{1'b0, 1'b1, 9'h106, 16'h0bad};
    @(posedge clk);
    dsp_access.index <= 9'h105;
    host_access <= '{1'b0, 1'b1, 9'h105, 16'h1234};
    @(posedge clk);
    dsp_access <= '0;
    host_access <= '0;
    clock_half_mode <= 1'b0;
    rdchk(9'h106, 16'h0bad);
    rdchk(9'h105, 16'h1234);
    chk("pixel_clock_out", {31'h0, pixel_clock_out}, 32'h1);
    @(negedge clk) #1 chk("pixel_clock_out", {31'h0, pixel_clock_out}, 32'h0);
  endtask
  // Verdict and end of run
  task automatic close_out();
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset and test sequence
  initial begin
    reset_n = 1'b0;
    host_access = '0;
    dsp_access = '0;
    stats_load = 1'b0;
    stats_ack = 1'b0;
    stats_in = '0;
    quant_pair = 7'h00;
    clock_half_mode = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_stats();
    t_table();
    close_out();
  end
endmodule
